// ==== include/gyro_sync_pkg.sv ====
// Constants and types shared by the rate sensor sync and mode controller
package gyro_sync_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Internal sampling at 2000 samples/s
    localparam int unsigned INT_RATE_SPS = 2000;
    localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000_000 / INT_RATE_SPS;
    localparam int unsigned SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    // Reference settle time and start-up stabilisation time
    localparam int unsigned SETTLE_US = 100;
    localparam int unsigned SETTLE_CYCLES_DEF = SETTLE_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_MS = 10;
    localparam int unsigned STARTUP_CYCLES_DEF = STARTUP_MS * 1_000_000 / CLK_PERIOD_NS;
    // Serial bit rate, rounded down to whole clock cycles
    localparam int unsigned BAUD_RATE = 921_600;
    localparam int unsigned BIT_CYCLES_DEF = CLK_HZ / BAUD_RATE;
    // Byte frame: start, eight data bits, stop
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam logic START_BIT = 1'b0;
    localparam logic STOP_BIT = 1'b1;
    localparam logic [9:0] LINE_IDLE = 10'h3FF;
    localparam logic [3:0] DIV_ZERO = 4'h0;
    localparam logic [31:0] CNT_ZERO = 32'h0;
    localparam logic [31:0] CNT_ONE = 32'h1;

    typedef enum logic [1:0] {
        DG_MEAS = 2'b00,
        DG_PART = 2'b01,
        DG_SERIAL = 2'b10,
        DG_CONFIG = 2'b11
    } dg_kind_type;

    typedef enum logic [2:0] {
        M_SETTLE = 3'b000,
        M_SYNC = 3'b001,
        M_SEND = 3'b010,
        M_NORMAL = 3'b011,
        M_SERVICE = 3'b100
    } mode_type;
endpackage

// ==== rtl/gyro_sync_ctrl.sv ====
// Sync, trigger, validity strobe and operating mode control of the rate sensor
////////////////////////////////////////////////////////////////////////////////
module gyro_sync_ctrl
    import gyro_sync_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF,
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYCLES_DEF,
    parameter int unsigned STARTUP_CYCLES = STARTUP_CYCLES_DEF,
    parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic reset_pin_low,
    input wire logic sample_request_in,
    input wire logic trig_mode,
    input wire logic [3:0] sample_div,
    input wire logic cmd_reset,
    input wire logic cmd_service,
    input wire logic svc_exit_init,
    input wire logic svc_exit_normal,
    input wire logic req_valid,
    input wire logic [1:0] req_kind,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_out,
    output logic dg_start,
    output logic [1:0] dg_kind,
    output logic dg_special,
    output logic chan_sync,
    output logic normal_mode,
    output logic startup_flag,
    output logic [31:0] latency_out,
    output logic validity_strobe,
    output logic factory_test_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; reset value high matches the internal pull-ups
    logic rst_s1_ff, rst_s2_ff;
    logic trig_s1_ff, trig_s2_ff, trig_d_ff;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= 1'b1;
            trig_s1_ff <= 1'b1;
            trig_s2_ff <= 1'b1;
            trig_d_ff <= 1'b1;
        end else begin
            rst_s1_ff <= reset_pin_low;
            rst_s2_ff <= rst_s1_ff;
            trig_s1_ff <= sample_request_in;
            trig_s2_ff <= trig_s1_ff;
            trig_d_ff <= trig_s2_ff;
        end
    end

    // Controller reset: system reset or a low reset pin
    wire ctl_rst = !rstn || !rst_s2_ff;
    wire trig_fall = trig_d_ff && !trig_s2_ff;

    ////////////////////////////////////////////////////////////////////////////
    // State
    mode_type mode_ff, nxt_mode;
    logic [31:0] tmr_ff, samp_cnt_ff, latency_ff;
    logic [3:0] div_cnt_ff;
    logic startup_ff, dg_active_ff, dg_start_ff, strobe_ff;
    logic pend_ff;
    dg_kind_type pend_kind_ff, init_kind_ff, dg_kind_ff;
    logic [9:0] shift_ff;
    logic [3:0] bit_ff;
    logic [31:0] baud_ff;
    logic ser_busy_ff, last_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire in_normal = mode_ff == M_NORMAL;
    wire samp_tick = samp_cnt_ff == SAMPLE_CYCLES - 1;
    wire half_tick = samp_cnt_ff == SAMPLE_CYCLES / 2;
    wire div_hit = div_cnt_ff == sample_div;
    wire bit_end = ser_busy_ff && baud_ff == BIT_CYCLES - 1;
    wire byte_end = bit_end && bit_ff == FRAME_LAST;
    wire dg_done = byte_end && last_ff;
    wire byte_take = tx_valid && tx_ready;
    wire settle_done = tmr_ff == SETTLE_CYCLES - 1;
    wire startup_done = tmr_ff == STARTUP_CYCLES - 1;

    // Datagram start sources
    wire init_go = mode_ff == M_SEND && !dg_active_ff;
    wire free_go = in_normal && !trig_mode && samp_tick && div_hit && !dg_active_ff;
    wire trig_go = in_normal && trig_mode && trig_fall && !dg_active_ff;
    wire start_dg = init_go || free_go || trig_go;
    wire last_init = mode_ff == M_SEND && dg_done && init_kind_ff == DG_CONFIG;

    // A pending special request takes the place of the measurement datagram
    dg_kind_type start_kind;
    assign start_kind = init_go ? init_kind_ff : (pend_ff ? pend_kind_ff : DG_MEAS);

    // Next mode
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            M_SETTLE: if (settle_done) nxt_mode = M_SYNC;
            M_SYNC: nxt_mode = M_SEND;
            M_SEND: if (last_init) nxt_mode = M_NORMAL;
            M_NORMAL: begin
                if (cmd_reset) begin
                    nxt_mode = M_SETTLE;
                end else if (cmd_service) begin
                    nxt_mode = M_SERVICE;
                end
            end
            M_SERVICE: begin
                if (svc_exit_init) begin
                    nxt_mode = M_SETTLE;
                end else if (svc_exit_normal) begin
                    nxt_mode = M_NORMAL;
                end
            end
            default: nxt_mode = M_SETTLE;
        endcase
    end

    wire to_init = nxt_mode == M_SETTLE && mode_ff != M_SETTLE;

    ////////////////////////////////////////////////////////////////////////////
    // Mode, timers and start-up flag
    always_ff @(posedge clk_sys) begin
        if (ctl_rst) begin
            mode_ff <= M_SETTLE;
            tmr_ff <= CNT_ZERO;
            startup_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            if (mode_ff != nxt_mode) begin
                tmr_ff <= CNT_ZERO;
            end else if (mode_ff == M_SETTLE || startup_ff) begin
                tmr_ff <= tmr_ff + CNT_ONE;
            end
            if (last_init) begin
                startup_ff <= 1'b1;
            end else if (mode_ff == M_SERVICE || (startup_ff && startup_done)) begin
                startup_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal sample clock keeps running in every normal configuration
    always_ff @(posedge clk_sys) begin
        if (ctl_rst) begin
            samp_cnt_ff <= CNT_ZERO;
            div_cnt_ff <= DIV_ZERO;
            latency_ff <= CNT_ZERO;
        end else begin
            samp_cnt_ff <= samp_tick ? CNT_ZERO : samp_cnt_ff + CNT_ONE;
            if (samp_tick) begin
                div_cnt_ff <= div_hit ? DIV_ZERO : div_cnt_ff + 4'h1;
            end
            if (trig_go) begin
                latency_ff <= samp_cnt_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Special datagram requests and datagram sequencing
    always_ff @(posedge clk_sys) begin
        if (ctl_rst) begin
            pend_ff <= 1'b0;
            pend_kind_ff <= DG_MEAS;
            init_kind_ff <= DG_PART;
            dg_active_ff <= 1'b0;
            dg_start_ff <= 1'b0;
            dg_kind_ff <= DG_MEAS;
        end else begin
            // A new request in the consuming cycle stays pending
            if (in_normal && req_valid) begin
                pend_ff <= 1'b1;
                pend_kind_ff <= dg_kind_type'(req_kind);
            end else if (start_dg && !init_go) begin
                pend_ff <= 1'b0;
            end
            if (mode_ff == M_SYNC) begin
                init_kind_ff <= DG_PART;
            end else if (mode_ff == M_SEND && dg_done && init_kind_ff != DG_CONFIG) begin
                init_kind_ff <= dg_kind_type'(init_kind_ff + 2'b01);
            end
            if (to_init) begin
                dg_active_ff <= 1'b0;
            end else if (start_dg) begin
                dg_active_ff <= 1'b1;
            end else if (dg_done) begin
                dg_active_ff <= 1'b0;
            end
            dg_start_ff <= start_dg;
            if (start_dg) begin
                dg_kind_ff <= start_kind;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte serialiser; the last byte's stop bit marks datagram end
    always_ff @(posedge clk_sys) begin
        if (ctl_rst) begin
            shift_ff <= LINE_IDLE;
            bit_ff <= DIV_ZERO;
            baud_ff <= CNT_ZERO;
            ser_busy_ff <= 1'b0;
            last_ff <= 1'b0;
        end else if (byte_take) begin
            shift_ff <= {STOP_BIT, tx_data, START_BIT};
            bit_ff <= DIV_ZERO;
            baud_ff <= CNT_ZERO;
            ser_busy_ff <= 1'b1;
            last_ff <= tx_last;
        end else if (bit_end) begin
            shift_ff <= {STOP_BIT, shift_ff[9:1]};
            baud_ff <= CNT_ZERO;
            bit_ff <= bit_ff + 4'h1;
            if (byte_end) begin
                ser_busy_ff <= 1'b0;
                last_ff <= 1'b0;
            end
        end else if (ser_busy_ff) begin
            baud_ff <= baud_ff + CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Validity strobe
    // Trigger configuration: plain half-period sync pulse, not a send marker
    always_ff @(posedge clk_sys) begin
        if (ctl_rst) begin
            strobe_ff <= 1'b1;
        end else if (in_normal && trig_mode) begin
            if (samp_tick) begin
                strobe_ff <= 1'b0;
            end else if (half_tick) begin
                strobe_ff <= 1'b1;
            end
        end else if (start_dg) begin
            strobe_ff <= 1'b0;
        end else if (dg_done) begin
            strobe_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign tx_ready = dg_active_ff && !ser_busy_ff;
    assign tx_out = shift_ff[0];
    assign dg_start = dg_start_ff;
    assign dg_kind = dg_kind_ff;
    assign dg_special = dg_kind_ff != DG_MEAS;
    assign chan_sync = mode_ff == M_SYNC;
    assign normal_mode = in_normal;
    assign startup_flag = startup_ff;
    assign latency_out = latency_ff;
    assign validity_strobe = strobe_ff;
    // Test pin is never driven active in the field
    assign factory_test_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (ctl_rst);

    a_free_run_start: assert property (
        free_go |=> dg_start && dg_active_ff)
        else $error("free-running datagram did not start");
    a_pin_reset_init: assert property (
        disable iff (!rstn) !rst_s2_ff |=> mode_ff == M_SETTLE)
        else $error("reset pin did not force init mode");
    a_trig_one_dg: assert property (
        trig_go |=> dg_start ##1 !dg_start)
        else $error("trigger edge did not start one datagram");
    a_pend_replace: assert property (
        trig_go && pend_ff && !req_valid |=> dg_kind == $past(pend_kind_ff) && !pend_ff)
        else $error("pending special datagram not sent on trigger");
    a_init_no_wait: assert property (
        init_go |=> dg_start && dg_special)
        else $error("init datagram waited");
    a_latency_capture: assert property (
        trig_go |=> latency_out == $past(samp_cnt_ff))
        else $error("latency not captured at trigger");
    a_trig_strobe_fall: assert property (
        in_normal && trig_mode && samp_tick |=> !validity_strobe)
        else $error("strobe did not fall on sample tick");
    a_strobe_rise_end: assert property (
        !(in_normal && trig_mode) && dg_done && !start_dg |=> validity_strobe)
        else $error("strobe did not rise after final bit");
    a_init_to_normal: assert property (
        last_init |=> normal_mode && startup_flag)
        else $error("no normal mode with start-up after third datagram");
    a_svc_skip_startup: assert property (
        mode_ff == M_SERVICE && svc_exit_normal && !svc_exit_init |=> normal_mode && !startup_flag)
        else $error("service exit set start-up flag");
    a_stop_bit_high: assert property (
        byte_end |-> tx_out == STOP_BIT)
        else $error("stop bit not high");
endmodule

// ==== test/dg_source.sv ====
// Datagram formatter and serial receiver standing at the controller's far side
module dg_source
    import gyro_sync_pkg::*;
#(
    parameter int BIT_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic dg_start,
    input wire logic [1:0] dg_kind,
    input wire logic tx_ready,
    input wire logic tx_out,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    output int rx_count,
    output logic [7:0] rx_byte,
    output int rx_errs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] idx_ff;
    logic [1:0] kind_ff;
    logic [3:0] len;
    // Special datagrams are longer than measurement ones
    assign len = (kind_ff == DG_MEAS) ? 4'h2 : 4'h3;
    assign tx_last = (idx_ff == len - 4'h1);
    assign tx_data = {kind_ff, 2'h0, idx_ff};
    // Byte held until taken; an aborted datagram is dropped at the next start
    always @(posedge clk_sys) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
            idx_ff <= 4'h0;
            kind_ff <= DG_MEAS;
        end else if (dg_start) begin
            tx_valid <= 1'b1;
            idx_ff <= 4'h0;
            kind_ff <= dg_kind;
        end else if (tx_valid && tx_ready) begin
            idx_ff <= idx_ff + 4'h1;
            if (tx_last) begin
                tx_valid <= 1'b0;
            end
        end
    end
    // Samples mid-bit, so the line's own edges never race the sampling
    initial begin
        rx_count = 0;
        rx_errs = 0;
        rx_byte = 8'h00;
        forever begin
            @(negedge tx_out);
            repeat (BIT_CYCLES / 2) @(posedge clk_sys);
            if (tx_out !== START_BIT) rx_errs++;
            for (int b = 0; b < 8; b++) begin
                repeat (BIT_CYCLES) @(posedge clk_sys);
                rx_byte[b] = tx_out;
            end
            repeat (BIT_CYCLES) @(posedge clk_sys);
            if (tx_out !== STOP_BIT) rx_errs++;
            rx_count++;
        end
    end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the sync and mode controller
module testbench
    import gyro_sync_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts keep the run brief
    localparam int unsigned SC = 200;
    localparam int unsigned ST = 20;
    localparam int unsigned SU = 50;
    localparam int unsigned BC = 4;
    logic clk_sys, rstn, reset_pin_low, sample_request_in, trig_mode;
    logic cmd_reset, cmd_service, svc_exit_init, svc_exit_normal, req_valid;
    logic [3:0] sample_div;
    logic [1:0] req_kind, dg_kind;
    logic [7:0] tx_data, rx_byte;
    logic tx_valid, tx_last, tx_ready, tx_out, dg_start, dg_special, chan_sync;
    logic normal_mode, startup_flag, validity_strobe, factory_test_out, strobe_q;
    logic [31:0] latency_out;
    logic [1:0] kinds[$];
    int rx_count, rx_errs, errors, checks_done, syncs, falls, last_dg, cyc;
    int last_fall, dg_gap;
    ////////////////////////////////////////////////////////////////////////////
    gyro_sync_ctrl #(.SAMPLE_CYCLES(SC), .SETTLE_CYCLES(ST), .STARTUP_CYCLES(SU),
        .BIT_CYCLES(BC)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .reset_pin_low(reset_pin_low), .sample_request_in(sample_request_in),
        .trig_mode(trig_mode), .sample_div(sample_div), .cmd_reset(cmd_reset),
        .cmd_service(cmd_service), .svc_exit_init(svc_exit_init),
        .svc_exit_normal(svc_exit_normal), .req_valid(req_valid), .req_kind(req_kind),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .tx_out(tx_out), .dg_start(dg_start), .dg_kind(dg_kind), .dg_special(dg_special),
        .chan_sync(chan_sync), .normal_mode(normal_mode), .startup_flag(startup_flag),
        .latency_out(latency_out), .validity_strobe(validity_strobe),
        .factory_test_out(factory_test_out));
    dg_source #(.BIT_CYCLES(BC)) host_u (.clk_sys(clk_sys), .rstn(rstn),
        .dg_start(dg_start), .dg_kind(dg_kind), .tx_ready(tx_ready), .tx_out(tx_out),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .rx_count(rx_count),
        .rx_byte(rx_byte), .rx_errs(rx_errs));
    ////////////////////////////////////////////////////////////////////////////
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        // Gap is taken before a fall in this same cycle can move the reference
        if (rstn && dg_start === 1'b1) begin
            kinds.push_back(dg_kind);
            last_dg = cyc;
            dg_gap = cyc - last_fall;
        end
        if (rstn && chan_sync === 1'b1) syncs++;
        if (rstn && validity_strobe === 1'b0 && strobe_q === 1'b1) begin
            falls++;
            last_fall = cyc;
        end
        strobe_q = validity_strobe;
        // Whole run needs about 5000 cycles
        if (cyc == 40000) begin
            errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic wait_dg(input int n);
        int k;
        k = 0;
        while (kinds.size() < n && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        check(kinds.size(), n);
    endtask
    task automatic trigger();
        @(negedge clk_sys);
        sample_request_in = 1'b0;
        repeat (20) @(negedge clk_sys);
        sample_request_in = 1'b1;
        repeat (300) @(negedge clk_sys);
    endtask
    task automatic init_seq();
        int k;
        int base;
        k = 0;
        base = rx_count;
        kinds.delete();
        syncs = 0;
        wait_dg(3);
        check({kinds[0], kinds[1], kinds[2]}, {DG_PART, DG_SERIAL, DG_CONFIG});
        while (normal_mode !== 1'b1 && k < 2000) begin
            @(negedge clk_sys);
            k++;
        end
        check(syncs, 1);
        check(rx_count - base, 9);
        check(rx_byte, 8'hC2);
        check(dg_special, 1'b1);
        check(startup_flag, 1'b1);
        repeat (SU + 4) @(negedge clk_sys);
        check(startup_flag, 1'b0);
        check(normal_mode, 1'b1);
    endtask
    task automatic trig_tests();
        int n;
        n = kinds.size();
        falls = 0;
        repeat (2 * SC) @(negedge clk_sys);
        check(falls, 2);
        check(kinds.size(), n);
        trigger();
        check(kinds.size(), n + 1);
        check(kinds[n], DG_MEAS);
        // Strobe fall and start pulse are both seen late; net offset is one cycle
        check(latency_out, (dg_gap + SC - 1) % SC);
        req_kind = 2'h1;
        pulse(req_valid);
        req_kind = 2'h3;
        pulse(req_valid);
        check(kinds.size(), n + 1);
        trigger();
        check(kinds.size(), n + 2);
        check(kinds[n + 1], DG_CONFIG);
        trigger();
        check(kinds.size(), n + 3);
        check(kinds[n + 2], DG_MEAS);
    endtask
    task automatic free_run();
        int t1;
        int n;
        n = kinds.size();
        // A request left pending in trigger mode goes out with the first free send
        req_kind = 2'h2;
        pulse(req_valid);
        trig_mode = 1'b0;
        wait_dg(n + 2);
        check(kinds[n], DG_SERIAL);
        t1 = last_dg;
        wait_dg(kinds.size() + 1);
        check(last_dg - t1, 2 * SC);
        check(validity_strobe, 1'b0);
        repeat (60) @(negedge clk_sys);
        check(validity_strobe, 1'b0);
        repeat (40) @(negedge clk_sys);
        check(validity_strobe, 1'b1);
        check(dg_special, 1'b0);
        trig_mode = 1'b1;
        repeat (400) @(negedge clk_sys);
    endtask
    task automatic mode_tests();
        pulse(cmd_reset);
        init_seq();
        reset_pin_low = 1'b0;
        repeat (6) @(negedge clk_sys);
        check(normal_mode, 1'b0);
        reset_pin_low = 1'b1;
        init_seq();
        pulse(cmd_service);
        check(normal_mode, 1'b0);
        pulse(svc_exit_normal);
        check(normal_mode, 1'b1);
        check(startup_flag, 1'b0);
        pulse(cmd_service);
        pulse(svc_exit_init);
        init_seq();
        check(rx_errs, 0);
        check(factory_test_out, 1'b0);
    endtask
    task automatic conclude();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk_sys, rstn, cmd_reset, cmd_service, svc_exit_init, svc_exit_normal} = 6'h00;
        {reset_pin_low, sample_request_in, trig_mode, req_valid} = 4'hE;
        {sample_div, req_kind} = 6'h04;
        {errors, checks_done, syncs, falls, last_dg, cyc} = {6{32'h0}};
        repeat (12) @(negedge clk_sys);
        rstn = 1'b1;
        init_seq();
        trig_tests();
        free_run();
        mode_tests();
        conclude();
    end
endmodule
